// [tmr_pkg.sv]
// Package: register map, field positions and reset values of the timer unit
package tmr_pkg;
    localparam int          NUM_CH           = 8;
    localparam logic [19:0] PCE_ADDR         = 20'hf00f0;
    localparam logic [19:0] MODE_BASE_ADDR   = 20'hf0190;
    localparam logic [19:0] MODE_LAST_ADDR   = 20'hf019e;
    localparam logic [19:0] PSEL_ADDR        = 20'hf01b6;
    localparam logic [19:0] CTRL_ADDR        = 20'hf01c0;
    localparam logic [19:0] DATA_BASE_ADDR   = 20'hf01d0;
    localparam logic [19:0] DATA_LAST_ADDR   = 20'hf01de;
    localparam logic [19:0] CNT_BASE_ADDR    = 20'hf0180;
    localparam logic [19:0] CNT_LAST_ADDR    = 20'hf018e;
    localparam logic [7:0]  PCE_RESET        = 8'h00;
    localparam logic [7:0]  PCE_WMASK        = 8'hb5;
    localparam int          PCE_UNIT_EN_BIT  = 0;
    localparam logic [15:0] PSEL_RESET       = 16'h0000;
    localparam logic [15:0] PSEL_WMASK       = 16'h33ff;
    localparam logic [15:0] MODE_RESET       = 16'h0000;
    localparam logic [15:0] MODE_WMASK       = 16'hdfcf;
    localparam logic [15:0] DATA_RESET       = 16'h0000;
    localparam logic [15:0] CNT_RESET        = 16'hffff;
    localparam int          MODE_CKS_LSB     = 14;
    localparam int          MODE_CCS_BIT     = 12;
    localparam int          MODE_AUX_BIT     = 11;
    localparam int          MODE_STS_LSB     = 8;
    localparam int          MODE_CIS_LSB     = 6;
    localparam int          MODE_MD_LSB      = 1;
    localparam logic [7:0]  AUX_CH_MASK      = 8'h5e;
    localparam logic [7:0]  WIDE_CLK_CH_MASK = 8'h0a;
    localparam int          PRESCALE_W       = 15;
    localparam logic [2:0]  STS_ONE_EDGE     = 3'h1;
    localparam logic [2:0]  STS_BOTH_EDGE    = 3'h2;
    localparam logic [2:0]  MD_CAPTURE       = 3'h2;
    localparam logic [2:0]  MD_CAP_ONE       = 3'h6;
    typedef enum logic [1:0] {
        EDGE_FALL     = 2'b00,
        EDGE_RISE     = 2'b01,
        EDGE_BOTH_LOW = 2'b10,
        EDGE_BOTH_HI  = 2'b11
    } edge_sel_t;
endpackage

// [timer_unit_clock_prescaler.sv]
// Timer unit clock gating, shared prescaler, channel mode and capture logic
`timescale 1ns/1ps
// How it works
// RQ1: In capture mode a capture trigger copies the counter into the data register.
// RQ2: Capture trigger is a mode-selected valid edge of the channel input pin.
// RQ3: Enable bit 0 gates the unit clock; at 0 the unit is held reset. The code keeps the data registers, which still accept writes.
// RQ4: With the enable bit set, control registers read and write normally.
// RQ5: With enable clear, control registers revert to reset and ignore writes.
// RQ6: Software writes zero to enable register bits 1, 3 and 6.
// RQ7: Bits 3..0 and 7..4 pick first and second clock, divide by 2^k.
// RQ8: Bits 9..8 pick third clock: divide by 2, 4, 16 or 64.
// RQ9: Bits 13..12 pick fourth clock: divide by 256, 1024, 4096, 16384.
// RQ10: Software changes a prescale field only while its users are disabled.
// RQ11: Software writes zero to prescaler bits 15, 14, 11 and 10.
// RQ12: Software stops all channels before changing the peripheral clock source.
// RQ13: Undivided clock with zero data gives no usable interrupt.
// RQ14: Each divided clock is a one-cycle pulse from its rising edge.
// RQ15: Mode register not rewritten while enabled, except edge select bits.
// RQ16: Bit 11 is master on 2, 4, 6; split on 1, 3; else zero.
// RQ17: Clock select 00 first, 01 third, 10 second, 11 fourth clock.
// RQ18: Only channels 1 and 3 accept the third and fourth clocks.
// RQ19: Selected operation clock drives edge detection; count source bit decides counting.
// RQ20: Count source 0 counts operation clock, 1 counts input edges.
// RQ21: Bit 11 on channels without that function reads zero, ignores writes.
// RQ22: One free-running 15-bit prescaler makes single-cycle enable pulses.
module timer_unit_clock_prescaler
    import tmr_pkg::*;
#(
    parameter int N_CH = NUM_CH
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // Register port
    input  wire logic [19:0]         addr,
    input  wire logic [15:0]         wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [15:0]         rdata,
    // Timer input pins
    input  wire logic [N_CH-1:0]     timer_input_pin,
    // Channel status
    output logic      [N_CH-1:0]     channel_enabled_status,
    output logic      [N_CH-1:0]     capture_pulse,
    output logic                     unit_enabled
);
    logic [7:0]            pce_reg;
    logic [15:0]           psel_reg;
    logic [15:0]           mode_reg [N_CH];
    logic [15:0]           data_reg [N_CH];
    logic [15:0]           cnt_reg  [N_CH];
    logic [N_CH-1:0]       en_reg;
    logic [N_CH-1:0]       pin_reg;
    logic [PRESCALE_W-1:0] pre_reg;
    logic [PRESCALE_W-1:0] pre_next;
    logic                  unit_on;
    logic [N_CH-1:0]       cap_next;

    assign unit_on  = pce_reg[PCE_UNIT_EN_BIT];
    assign pre_next = pre_reg + PRESCALE_W'(1);

    // Pulse while low k bits of the prescaler are all ones: one cycle every 2^k
    function automatic logic div_tick(input logic [PRESCALE_W-1:0] cnt_now, input int k);
        logic [PRESCALE_W-1:0] low_mask;
        low_mask = PRESCALE_W'((32'h1 << k) - 32'h1);
        return &(cnt_now | ~low_mask);
    endfunction

    // Index of a channel register from its word address
    function automatic logic [2:0] ch_index(input logic [19:0] a, input logic [19:0] base);
        logic [19:0] off;
        off = a - base;
        return off[3:1];
    endfunction

    // Peripheral enable register; never cleared by the unit itself
    always_ff @(posedge clk) begin
        if (srst) begin
            pce_reg <= PCE_RESET;
        end else if (wr && addr == PCE_ADDR) begin
            pce_reg <= wdata[7:0] & PCE_WMASK;
        end
    end

    // Shared prescaler counter, held cleared while the unit is gated off
    always_ff @(posedge clk) begin
        if (srst || !unit_on) begin // see RQ3
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_next; // see RQ22
        end
    end

    logic [3:0] code_a;
    logic [3:0] code_b;
    logic [1:0] code_c;
    logic [1:0] code_d;
    logic       tick_a;
    logic       tick_b;
    logic       tick_c;
    logic       tick_d;
    assign code_a = psel_reg[3:0];
    assign code_b = psel_reg[7:4];
    assign code_c = psel_reg[9:8];
    assign code_d = psel_reg[13:12];
    // Ticks are one-cycle enables, not new clocks, to avoid gated clock skew
    assign tick_a = unit_on && div_tick(pre_reg, int'(code_a)); // see RQ7 see RQ14
    assign tick_b = unit_on && div_tick(pre_reg, int'(code_b)); // see RQ7 see RQ14
    assign tick_c = unit_on && div_tick(pre_reg, (code_c == 2'd0) ? 1 :
                                                  int'(code_c) * 2); // see RQ8
    assign tick_d = unit_on && div_tick(pre_reg, 8 + int'(code_d) * 2); // see RQ9

    // Control registers: reset while gated off, writes ignored then
    always_ff @(posedge clk) begin
        if (srst || !unit_on) begin // see RQ5
            psel_reg <= PSEL_RESET;
        end else if (wr && addr == PSEL_ADDR) begin // see RQ4
            psel_reg <= wdata & PSEL_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !unit_on) begin // see RQ5
            en_reg <= '0;
        end else if (wr && addr == CTRL_ADDR) begin
            en_reg <= wdata[N_CH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !unit_on) begin // see RQ5
            pin_reg <= '0;
        end else begin
            pin_reg <= timer_input_pin;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            logic [15:0] wmask;
            logic [1:0]  cks;
            logic [2:0]  sts;
            logic [2:0]  md;
            logic [1:0]  cis;
            logic        op_tick;
            logic        rise;
            logic        fall;
            logic        edge_ok;
            logic        capture_mode;
            logic        count_tick;
            logic        trig;
            assign wmask = AUX_CH_MASK[g] ? MODE_WMASK :
                           (MODE_WMASK & ~(16'h0001 << MODE_AUX_BIT)); // see RQ16 see RQ21
            assign cks = mode_reg[g][MODE_CKS_LSB +: 2];
            assign sts = mode_reg[g][MODE_STS_LSB +: 3];
            assign md  = mode_reg[g][MODE_MD_LSB +: 3];
            assign cis = mode_reg[g][MODE_CIS_LSB +: 2];
            // Channels without wide clock access fall back to the first pair
            always_comb begin
                unique case (cks) // see RQ17 see RQ18
                    2'b00: op_tick = tick_a;
                    2'b01: op_tick = WIDE_CLK_CH_MASK[g] ? tick_c : tick_a;
                    2'b10: op_tick = tick_b;
                    2'b11: op_tick = WIDE_CLK_CH_MASK[g] ? tick_d : tick_b;
                endcase
            end
            // Edge detection samples on the operation clock
            logic pin_prev;
            always_ff @(posedge clk) begin
                if (srst || !unit_on) begin
                    pin_prev <= 1'b0;
                end else if (op_tick) begin // see RQ19
                    pin_prev <= pin_reg[g];
                end
            end
            assign rise = op_tick && pin_reg[g] && !pin_prev;
            assign fall = op_tick && !pin_reg[g] && pin_prev;
            always_comb begin
                unique case (edge_sel_t'(cis)) // see RQ2
                    EDGE_FALL:     edge_ok = fall;
                    EDGE_RISE:     edge_ok = rise;
                    EDGE_BOTH_LOW: edge_ok = (sts == STS_BOTH_EDGE) ? (rise || fall) : rise;
                    EDGE_BOTH_HI:  edge_ok = (sts == STS_BOTH_EDGE) ? (rise || fall) : fall;
                endcase
            end
            assign capture_mode = (md == MD_CAPTURE) || (md == MD_CAP_ONE);
            assign trig = en_reg[g] && capture_mode && edge_ok &&
                          (sts == STS_ONE_EDGE || sts == STS_BOTH_EDGE); // see RQ2
            assign count_tick = mode_reg[g][MODE_CCS_BIT] ? edge_ok : op_tick; // see RQ20
            assign cap_next[g] = trig;

            always_ff @(posedge clk) begin
                if (srst || !unit_on) begin // see RQ5
                    mode_reg[g] <= MODE_RESET;
                end else if (wr && addr == MODE_BASE_ADDR + 20'(2 * g)) begin
                    mode_reg[g] <= wdata & wmask; // see RQ21
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    data_reg[g] <= DATA_RESET;
                end else if (trig) begin
                    data_reg[g] <= cnt_reg[g]; // see RQ1
                end else if (wr && addr == DATA_BASE_ADDR + 20'(2 * g)) begin
                    data_reg[g] <= wdata;
                end
            end

            // Up counter for capture modes only; other modes lie outside this block
            always_ff @(posedge clk) begin
                if (srst || !unit_on) begin // see RQ3
                    cnt_reg[g] <= CNT_RESET;
                end else if (!en_reg[g]) begin
                    cnt_reg[g] <= capture_mode ? 16'h0000 : cnt_reg[g];
                end else if (trig) begin
                    cnt_reg[g] <= 16'h0000;
                end else if (count_tick && capture_mode) begin
                    cnt_reg[g] <= cnt_reg[g] + 16'h0001;
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    logic [15:0] rdata_next;
    always_comb begin
        rdata_next = 16'h0000;
        if (addr == PCE_ADDR) begin
            rdata_next = {8'h00, pce_reg};
        end else if (addr == PSEL_ADDR) begin
            rdata_next = psel_reg;
        end else if (addr == CTRL_ADDR) begin
            rdata_next = 16'(en_reg);
        end else if (addr >= MODE_BASE_ADDR && addr <= MODE_LAST_ADDR && !addr[0]) begin
            rdata_next = mode_reg[ch_index(addr, MODE_BASE_ADDR)];
        end else if (addr >= DATA_BASE_ADDR && addr <= DATA_LAST_ADDR && !addr[0]) begin
            rdata_next = data_reg[ch_index(addr, DATA_BASE_ADDR)];
        end else if (addr >= CNT_BASE_ADDR && addr <= CNT_LAST_ADDR && !addr[0]) begin
            rdata_next = cnt_reg[ch_index(addr, CNT_BASE_ADDR)];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd ? rdata_next : 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            capture_pulse          <= '0;
            channel_enabled_status <= '0;
            unit_enabled           <= 1'b0;
        end else begin
            capture_pulse          <= cap_next;
            channel_enabled_status <= en_reg;
            unit_enabled           <= unit_on;
        end
    end

    // Checks
    property p_gate_reset;
        @(posedge clk) disable iff (srst)
        !unit_on |=> psel_reg == PSEL_RESET && en_reg == '0;
    endproperty
    a_gate_reset: assert property (p_gate_reset) // see RQ5
        else $error("control not reset while unit off");
    property p_no_tick_off;
        @(posedge clk) disable iff (srst)
        !unit_on |-> !tick_a && !tick_b && !tick_c && !tick_d;
    endproperty
    a_no_tick_off: assert property (p_no_tick_off) // see RQ3
        else $error("tick while unit off");
    property p_tick_one_cycle;
        @(posedge clk) disable iff (srst)
        tick_c && code_c != 2'd0 && $stable(psel_reg) |=> !tick_c;
    endproperty
    a_tick_one_cycle: assert property (p_tick_one_cycle) // see RQ14
        else $error("divided tick longer than one cycle");
    property p_d_spacing;
        @(posedge clk) disable iff (srst)
        tick_d && code_d == 2'd0 |=> !tick_d [*8];
    endproperty
    a_d_spacing: assert property (p_d_spacing) // see RQ9
        else $error("fourth clock too fast");
    property p_a_full;
        @(posedge clk) disable iff (srst)
        unit_on && code_a == 4'd0 |-> tick_a;
    endproperty
    a_a_full: assert property (p_a_full) // see RQ7
        else $error("undivided clock missing");
    property p_aux_zero;
        @(posedge clk) disable iff (srst)
        !mode_reg[0][MODE_AUX_BIT] && !mode_reg[5][MODE_AUX_BIT] && !mode_reg[7][MODE_AUX_BIT];
    endproperty
    a_aux_zero: assert property (p_aux_zero) // see RQ21
        else $error("bit 11 set on plain channel");
    property p_capture;
        @(posedge clk) disable iff (srst)
        unit_on && cap_next[3] |=> data_reg[3] == $past(cnt_reg[3]);
    endproperty
    a_capture: assert property (p_capture) // see RQ1
        else $error("capture value wrong");
    property p_write_ok;
        @(posedge clk) disable iff (srst)
        unit_on && wr && addr == PSEL_ADDR |=> psel_reg == ($past(wdata) & PSEL_WMASK);
    endproperty
    a_write_ok: assert property (p_write_ok) // see RQ4
        else $error("prescaler write lost");
    c_capture: cover property (@(posedge clk) cap_next != '0);
    c_tick_d: cover property (@(posedge clk) tick_d && code_d == 2'd0);
    c_unit_off: cover property (@(posedge clk) unit_on ##1 !unit_on);
endmodule

// [test_timer_unit_clock_prescaler.sv]
// Self-checking testbench for the timer unit clock prescaler
`timescale 1ns/1ps
module test_timer_unit_clock_prescaler
    import tmr_pkg::*;
;
    logic        clk   = 1'b0;
    logic        srst  = 1'b1;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [19:0] addr  = 20'h00000;
    logic [15:0] wdata = 16'h0000;
    logic [7:0]  pin   = 8'h00;
    logic [7:0]  lfsr  = 8'h44;
    logic [15:0] rdata;
    logic [15:0] rv;
    logic [15:0] c0;
    logic [15:0] cv;
    logic [15:0] ps;
    logic [7:0]  ces;
    logic [7:0]  cap;
    logic        uen;
    int          err_count  = 0;
    int          num_checks = 0;
    int          k;

    always #12.5 clk = ~clk;

    timer_unit_clock_prescaler dut (
        .clk                    (clk),
        .srst                   (srst),
        .addr                   (addr),
        .wdata                  (wdata),
        .wr                     (wr),
        .rd                     (rd),
        .rdata                  (rdata),
        .timer_input_pin        (pin),
        .channel_enabled_status (ces),
        .capture_pulse          (cap),
        .unit_enabled           (uen)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Divide ratio of the clock a channel should pick
    function automatic int div_of(input int ch, input int cks, input logic [15:0] p);
        logic w;
        w = WIDE_CLK_CH_MASK[ch];
        case (cks)
            0:       return 1 << p[3:0];
            2:       return 1 << p[7:4];
            1:       return w ? 2 << (p[9:8] == 2'b00 ? 0 : 2 * p[9:8] - 1) : 1 << p[3:0];
            default: return w ? 256 << (2 * p[13:12]) : 1 << p[7:4];
        endcase
    endfunction

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [19:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [19:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask

    // Long waits so a slow operation clock still sees both pin levels
    task automatic measure(input int ch, input int cks);
        lfsr = lfsr_next(lfsr);
        ps = {3'b000, lfsr[7], 2'b00, lfsr[6:5], 1'b0, lfsr[4:2], 2'b00, lfsr[1:0]};
        wr_reg(CTRL_ADDR, 16'h0000);
        pin[ch] <= 1'b0;
        wr_reg(PSEL_ADDR, ps);
        wr_reg(MODE_BASE_ADDR + 20'(2 * ch), 16'(cks << 14) | 16'h0144);
        wr_reg(CTRL_ADDR, 16'(1 << ch));
        repeat (1100) @(posedge clk);
        pin[ch] <= 1'b1;
        repeat (1100) @(posedge clk);
        rd_reg(CNT_BASE_ADDR + 20'(2 * ch));
        c0 = rv;
        repeat (2046) @(posedge clk);
        rd_reg(CNT_BASE_ADDR + 20'(2 * ch));
        check("tick_rate", rv - c0, 16'(2048 / div_of(ch, cks, ps)));
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Budget covers eight rate runs plus register traffic
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd_reg(PCE_ADDR);
        check("enable_reset", rv, 16'h0000);
        wr_reg(PSEL_ADDR, 16'h0fff);
        rd_reg(PSEL_ADDR);
        check("psel_locked", rv, 16'h0000);
        check("unit_off", {15'h0000, uen}, 16'h0000);
        $display("test disabled unit done");
        wr_reg(PCE_ADDR, 16'h00ff);
        rd_reg(PCE_ADDR);
        check("enable_mask", rv, 16'h00b5);
        check("unit_on", {15'h0000, uen}, 16'h0001);
        wr_reg(PSEL_ADDR, 16'hffff);
        rd_reg(PSEL_ADDR);
        check("psel_mask", rv, 16'h33ff);
        rd_reg(20'hf0100);
        check("unmapped", rv, 16'h0000);
        for (k = 0; k < 8; k++) begin
            wr_reg(MODE_BASE_ADDR + 20'(2 * k), 16'hffff);
            rd_reg(MODE_BASE_ADDR + 20'(2 * k));
            check("mode_rw", rv, (k == 0 || k == 5 || k == 7) ? 16'hd7cf : 16'hdfcf);
            wr_reg(MODE_BASE_ADDR + 20'(2 * k), 16'h0000);
        end
        $display("test registers done");
        for (k = 0; k < 8; k++)
            measure(k / 4, k % 4);
        $display("test clock select done");
        wr_reg(CTRL_ADDR, 16'h0000);
        wr_reg(PSEL_ADDR, 16'h0000);
        wr_reg(MODE_BASE_ADDR + 20'h00006, 16'h0144);
        wr_reg(CTRL_ADDR, 16'h0008);
        pin[3] <= 1'b0;
        repeat (4) @(posedge clk);
        pin[3] <= 1'b1;
        repeat (40) @(posedge clk);
        check("chan_status", {8'h00, ces}, 16'h0008);
        pin[3] <= 1'b0;
        rd_reg(CNT_BASE_ADDR + 20'h00006);
        c0 = rv;
        @(posedge clk);
        pin[3] <= 1'b1;
        k = 0;
        while (cap[3] !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("cap_pulse", {15'h0000, cap[3]}, 16'h0001);
        rd_reg(DATA_BASE_ADDR + 20'h00006);
        cv = rv;
        check("cap_value", {15'h0000, (cv - c0) <= 16'h0010}, 16'h0001);
        rd_reg(CNT_BASE_ADDR + 20'h00006);
        check("cnt_cleared", {15'h0000, rv <= 16'h0010}, 16'h0001);
        $display("test capture done");
        // Count source 1 with trigger select 0, so no capture trigger: counter steps on rising input edges
        wr_reg(CTRL_ADDR, 16'h0000);
        pin[3] <= 1'b0;
        wr_reg(MODE_BASE_ADDR + 20'h00006, 16'h1044);
        wr_reg(CTRL_ADDR, 16'h0008);
        lfsr = lfsr_next(lfsr);
        repeat (int'(lfsr[3:0]) + 1) begin
            @(posedge clk);
            pin[3] <= 1'b1;
            repeat (3) @(posedge clk);
            pin[3] <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        rd_reg(CNT_BASE_ADDR + 20'h00006);
        check("edge_count", rv, 16'(lfsr[3:0]) + 16'h0001);
        $display("test edge count done");
        wr_reg(PCE_ADDR, 16'h0000);
        rd_reg(MODE_BASE_ADDR + 20'h00006);
        check("mode_cleared", rv, 16'h0000);
        check("unit_off2", {15'h0000, uen}, 16'h0000);
        check("status_off", {8'h00, ces}, 16'h0000);
        rd_reg(DATA_BASE_ADDR + 20'h00006);
        check("data_kept", rv, cv);
        $display("test unit disable done");
        give_verdict();
    end
endmodule
